/* hdl/ffr_regs.sv */
// function and read parameter registers with serial command front end
`timescale 1ns/1ps
module ffr_regs (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_si,
   output logic o_so,
   output logic o_so_oe,
   input wire logic i_pkg_has_dedicated_reset,
   input wire logic i_quad_lane_enable,
   input wire logic i_four_wire_command_mode,
   input wire logic i_suspend_cmd,
   input wire logic i_resume_cmd,
   input wire logic i_program_busy,
   input wire logic i_erase_busy,
   input wire logic i_row_prog_req,
   input wire logic [1:0] i_row_sel,
   input wire ffr_pkg::ffr_read_class_t i_read_class,
   input wire logic i_read_load,
   input wire logic i_read_step,
   input wire logic [ffr_pkg::FFR_ADDR_W-1:0] i_read_start,
   output ffr_pkg::ffr_func_t o_func,
   output ffr_pkg::ffr_read_params_t o_read_params_nv,
   output ffr_pkg::ffr_read_params_t o_read_params,
   output ffr_pkg::ffr_pin_mode_t o_shared_pin_mode,
   output logic o_wp_pin_is_data2,
   output logic o_dedicated_reset_enable,
   output logic o_protect_at_bottom,
   output logic o_row_prog_allow,
   output logic [3:0] o_dummy_cycles,
   output logic [6:0] o_burst_bytes,
   output logic [ffr_pkg::FFR_ADDR_W-1:0] o_read_addr
);
   import ffr_pkg::*;

   typedef enum logic [1:0] {st_opcode, st_data_in, st_data_out, st_ignore} ffr_state_t;

   logic [2:0] sclk_sync, cs_sync, si_sync;
   logic sclk_rise, sclk_fall, cs_idle, si_bit;
   ffr_state_t state;
   logic [2:0] bit_cnt;
   logic [7:0] sh_in, sh_out, opcode;
   logic byte_done, wr_nv, wr_v, wr_func;
   logic init_done;
   ffr_func_t func;
   ffr_read_params_t rp_nv, rp_v;
   logic [7:0] rx_byte;
   logic [ffr_pkg::FFR_ADDR_W-1:0] next_addr;
   logic [5:0] win_mask;

   // default dummy count per read command
   function automatic logic [3:0] ffr_default_dummy(input ffr_read_class_t rc);
      case (rc)
         ffr_rc_fast_qpi, ffr_rc_quad_io: ffr_default_dummy = FFR_DUMMY_6;
         ffr_rc_dual_io: ffr_default_dummy = FFR_DUMMY_4;
         default: ffr_default_dummy = FFR_DUMMY_8;
      endcase
   endfunction

   // burst code to byte count, window mask derived from it below
   function automatic logic [6:0] ffr_burst(input logic [1:0] code);
      case (code)
         2'h0: ffr_burst = FFR_BURST_8;
         2'h1: ffr_burst = FFR_BURST_16;
         2'h2: ffr_burst = FFR_BURST_32;
         default: ffr_burst = FFR_BURST_64;
      endcase
   endfunction

   // two-stage synchronisers, third stage only for edge finding
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sclk_sync <= 3'h0;
         cs_sync <= 3'h7;
         si_sync <= 3'h0;
      end else begin
         sclk_sync <= {sclk_sync[1:0], i_sclk};
         cs_sync <= {cs_sync[1:0], i_cs_n};
         si_sync <= {si_sync[1:0], i_si};
      end
   end

   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
   assign cs_idle = cs_sync[1];
   assign si_bit = si_sync[1];
   assign rx_byte = {sh_in[6:0], si_bit};
   assign byte_done = !cs_idle && sclk_rise && bit_cnt == FFR_BIT_LAST;
   assign wr_nv = byte_done && state == st_data_in && opcode == FFR_OP_SET_RP_NV;
   assign wr_v = byte_done && state == st_data_in &&
      (opcode == FFR_OP_SET_RP_V0 || opcode == FFR_OP_SET_RP_V1);
   assign wr_func = byte_done && state == st_data_in && opcode == FFR_OP_WR_FUNC;

   // command sequencer on sampled serial clock edges
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= st_opcode;
         bit_cnt <= 3'h0;
         sh_in <= 8'h00;
         opcode <= 8'h00;
      end else if (cs_idle) begin
         state <= st_opcode;
         bit_cnt <= 3'h0;
      end else if (sclk_rise) begin
         sh_in <= rx_byte;
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == FFR_BIT_LAST) begin
            case (state)
               st_opcode: begin
                  opcode <= rx_byte;
                  if (rx_byte == FFR_OP_RD_FUNC || rx_byte == FFR_OP_RD_RP)
                     state <= st_data_out;
                  else if (rx_byte == FFR_OP_SET_RP_NV || rx_byte == FFR_OP_SET_RP_V0 ||
                           rx_byte == FFR_OP_SET_RP_V1 || rx_byte == FFR_OP_WR_FUNC)
                     state <= st_data_in;
                  else
                     state <= st_ignore;
               end
               st_data_in: state <= st_ignore;
               st_data_out: state <= st_data_out;
               default: state <= st_ignore;
            endcase
         end
      end
   end

   // read data shifted out on falling edges, register repeats
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sh_out <= 8'h00;
         o_so <= 1'b0;
         o_so_oe <= 1'b0;
      end else if (cs_idle) begin
         o_so_oe <= 1'b0;
      end else if (state == st_opcode && byte_done) begin
         sh_out <= (rx_byte == FFR_OP_RD_FUNC) ? func : rp_v;
      end else if (state == st_data_out && sclk_fall) begin
         o_so <= sh_out[7];
         o_so_oe <= 1'b1;
         sh_out <= {sh_out[6:0], sh_out[7]};
      end
   end

   // function register: one-time bits only set, suspend flags volatile
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         func <= FFR_FUNC_RESET;
      end else begin
         // package without dedicated pin reads disabled from the start
         if (!init_done && !i_pkg_has_dedicated_reset)
            func.restart_pin_disable <= 1'b1;
         if (wr_func) begin
            func.restart_pin_disable <= func.restart_pin_disable | rx_byte[0];
            func.protect_area_side_select <= func.protect_area_side_select | rx_byte[1];
            {func.info_row3_lock, func.info_row2_lock, func.info_row1_lock,
             func.info_row0_lock} <= {func.info_row3_lock, func.info_row2_lock,
             func.info_row1_lock, func.info_row0_lock} | rx_byte[7:4];
         end
         // program suspend, set wins over resume
         if (i_suspend_cmd && i_program_busy)
            func.program_suspended_flag <= 1'b1;
         else if (i_resume_cmd)
            func.program_suspended_flag <= 1'b0;
         // erase suspend, set wins over resume
         if (i_suspend_cmd && i_erase_busy)
            func.erase_suspended_flag <= 1'b1;
         else if (i_resume_cmd)
            func.erase_suspended_flag <= 1'b0;
      end
   end

   // read parameter pair, volatile loaded once after reset release
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rp_nv <= FFR_RP_RESET;
         rp_v <= FFR_RP_RESET;
         init_done <= 1'b0;
      end else begin
         init_done <= 1'b1;
         if (!init_done)
            rp_v <= rp_nv;
         else if (wr_v)
            rp_v <= rx_byte;
         if (wr_nv)
            rp_nv <= rx_byte;
      end
   end

   // wrap window of the current burst
   assign win_mask = 6'(ffr_burst({rp_v.burst_len_hi, rp_v.burst_len_lo}) - 7'h01);
   // step inside aligned window or across whole array
   always_comb begin
      next_addr = o_read_addr + 24'h000001;
      // wrap only when bit 2 is set
      if (rp_v.wrap_boundary_select)
         next_addr = {o_read_addr[FFR_ADDR_W-1:6],
            (o_read_addr[5:0] & ~win_mask) | ((o_read_addr[5:0] + 6'h01) & win_mask)};
   end

   // read address counter
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n)
         o_read_addr <= '0;
      else if (i_read_load)
         o_read_addr <= i_read_start;
      else if (i_read_step)
         o_read_addr <= next_addr;
   end

   // registered decoded outputs
   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_func <= FFR_FUNC_RESET;
         o_read_params_nv <= FFR_RP_RESET;
         o_read_params <= FFR_RP_RESET;
         o_shared_pin_mode <= ffr_pin_pause;
         o_wp_pin_is_data2 <= 1'b0;
         o_dedicated_reset_enable <= 1'b0;
         o_protect_at_bottom <= 1'b0;
         o_row_prog_allow <= 1'b0;
         o_dummy_cycles <= FFR_DUMMY_8;
         o_burst_bytes <= FFR_BURST_8;
      end else begin
         o_func <= func;
         o_read_params_nv <= rp_nv;
         o_read_params <= rp_v;
         // quad enable turns control pins to data
         o_wp_pin_is_data2 <= i_quad_lane_enable;
         o_dedicated_reset_enable <= i_pkg_has_dedicated_reset & ~func.restart_pin_disable;
         o_protect_at_bottom <= func.protect_area_side_select;
         o_row_prog_allow <= i_row_prog_req & ~func[4 + 32'(i_row_sel)];
         if (i_quad_lane_enable || i_four_wire_command_mode)
            o_shared_pin_mode <= ffr_pin_data_line_three;
         // dedicated pin still live forces pause
         else if (i_pkg_has_dedicated_reset && !func.restart_pin_disable)
            o_shared_pin_mode <= ffr_pin_pause;
         else
            o_shared_pin_mode <= rp_v.pin_function_select ? ffr_pin_restart : ffr_pin_pause;
         // programmed dummy count, default when zero
         o_dummy_cycles <= (rp_v.dummy == FFR_DUMMY_USE_DEFAULT) ?
            ffr_default_dummy(i_read_class) : rp_v.dummy;
         o_burst_bytes <= ffr_burst({rp_v.burst_len_hi, rp_v.burst_len_lo});
      end
   end

   a_restart_disable_sticky: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      func.restart_pin_disable |=> func.restart_pin_disable) else $error("disable bit cleared");
   a_side_select_sticky: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      o_protect_at_bottom |=> o_protect_at_bottom) else $error("bottom reverted to top");
   a_row_lock_sticky: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      $fell(func.info_row0_lock) == 1'b0) else $error("row lock cleared");
   a_prog_susp_set: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      i_suspend_cmd && i_program_busy |=> ##1 o_func.program_suspended_flag)
      else $error("program suspend flag not set");
   a_erase_susp_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      i_resume_cmd && !i_suspend_cmd |=> ##1 !o_func.erase_suspended_flag)
      else $error("erase suspend flag not cleared");
   a_row_block_prog: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      i_row_prog_req && func[4 + 32'(i_row_sel)] |=> !o_row_prog_allow)
      else $error("locked row allowed");
   a_nv_untouched: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      wr_v |=> $stable(rp_nv)) else $error("volatile write changed stored copy");
   a_data3_pin: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      i_quad_lane_enable |=> o_shared_pin_mode == ffr_pin_data_line_three)
      else $error("shared pin not data line");
   a_pause_forced: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      !i_quad_lane_enable && !i_four_wire_command_mode && i_pkg_has_dedicated_reset &&
      !func.restart_pin_disable |=> o_shared_pin_mode == ffr_pin_pause)
      else $error("pause not forced");
   a_dummy_dual_io: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      rp_v.dummy == 4'h0 && i_read_class == ffr_rc_dual_io |=> o_dummy_cycles == 4'h4)
      else $error("dual io default dummy wrong");
   a_wrap_in_window: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      i_read_step && !i_read_load && rp_v.wrap_boundary_select |=>
      o_read_addr[FFR_ADDR_W-1:6] == $past(o_read_addr[FFR_ADDR_W-1:6]) &&
      (o_read_addr[FFR_ADDR_W-1:3] == $past(o_read_addr[FFR_ADDR_W-1:3]) ||
      {rp_v.burst_len_hi, rp_v.burst_len_lo} != 2'h0)) else $error("wrap left window");
endmodule

/* hdl/ffr_pkg.sv */
// constants and types for the flash function and read parameter registers
package ffr_pkg;
   // command opcodes
   localparam logic [7:0] FFR_OP_SET_RP_NV = 8'h65;
   localparam logic [7:0] FFR_OP_SET_RP_V0 = 8'hc0;
   localparam logic [7:0] FFR_OP_SET_RP_V1 = 8'h63;
   // local opcodes, values arbitrary
   localparam logic [7:0] FFR_OP_RD_FUNC = 8'ha1;
   localparam logic [7:0] FFR_OP_RD_RP = 8'ha2;
   localparam logic [7:0] FFR_OP_WR_FUNC = 8'ha3;
   // read parameter reset value
   localparam logic [7:0] FFR_RP_RESET = 8'h00;
   localparam logic [7:0] FFR_FUNC_RESET = 8'h00;
   // default dummy counts
   localparam logic [3:0] FFR_DUMMY_8 = 4'h8;
   localparam logic [3:0] FFR_DUMMY_6 = 4'h6;
   localparam logic [3:0] FFR_DUMMY_4 = 4'h4;
   localparam logic [3:0] FFR_DUMMY_USE_DEFAULT = 4'h0;
   // burst lengths in bytes
   localparam logic [6:0] FFR_BURST_8 = 7'h08;
   localparam logic [6:0] FFR_BURST_16 = 7'h10;
   localparam logic [6:0] FFR_BURST_32 = 7'h20;
   localparam logic [6:0] FFR_BURST_64 = 7'h40;
   localparam logic [2:0] FFR_BIT_LAST = 3'h7;
   localparam int FFR_ADDR_W = 24;

   typedef struct packed {
      logic pin_function_select;
      logic [3:0] dummy;
      logic wrap_boundary_select;
      logic burst_len_hi;
      logic burst_len_lo;
   } ffr_read_params_t;

   typedef struct packed {
      logic info_row3_lock;
      logic info_row2_lock;
      logic info_row1_lock;
      logic info_row0_lock;
      logic erase_suspended_flag;
      logic program_suspended_flag;
      logic protect_area_side_select;
      logic restart_pin_disable;
   } ffr_func_t;

   typedef enum logic [2:0] {
      ffr_rc_fast_spi, ffr_rc_fast_qpi, ffr_rc_dual_out,
      ffr_rc_dual_io, ffr_rc_quad_out, ffr_rc_quad_io
   } ffr_read_class_t;

   typedef enum logic [1:0] {
      ffr_pin_pause, ffr_pin_restart, ffr_pin_data_line_three
   } ffr_pin_mode_t;
endpackage

/* test/ffr_host_model.sv */
// serial host model that drives mode 0 frames on the link
`timescale 1ns/1ps
module ffr_host_model (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_si,
   input wire logic i_so
);
   // idle link: clock stands still low, select high
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
   // opcode byte, then data byte
   // n bits msb first; the answer byte is sampled just before rises 9 to 16
   task automatic frame(input logic [7:0] op, input logic [7:0] dat, input int n,
      output logic [7:0] rd);
      logic [15:0] sh;
      sh = {op, dat};
      rd = 8'h00;
      #37.3 o_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         #40 o_si = sh[15-i];
         #40 if (i > 7) rd = {rd[6:0], i_so};
         o_sclk = 1'b1;
         #80 o_sclk = 1'b0;
      end
      #40 o_si = ~o_si;  // released line shows the inverse
      #40 o_cs_n = 1'b1;
      #120;
   endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the function and read parameter registers
`timescale 1ns/1ps
module testbench;
   import ffr_pkg::*;
   logic i_mclk, i_reset_n, sclk, cs_n, si, so, so_oe, strap, quad, fw, susp, resm;
   logic pbusy, ebusy, rreq, rload, rstep, wp2, dre, pbot, rallow;
   logic [1:0] rsel;
   logic [3:0] dcyc;
   logic [6:0] bbytes;
   logic [23:0] rstart, raddr, ea;
   logic [7:0] rd, d, exp_func, exp_rp, exp_nv;
   ffr_read_class_t rcls;
   ffr_func_t func;
   ffr_read_params_t rp, rp_nv;
   ffr_pin_mode_t pmode;
   int err_count, tests_run, seed, oe_cnt, oe_mark;
   ffr_read_class_t cls_tab [6] = '{ffr_rc_fast_spi, ffr_rc_fast_qpi, ffr_rc_dual_out,
      ffr_rc_dual_io, ffr_rc_quad_out, ffr_rc_quad_io};

   ffr_regs dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_pkg_has_dedicated_reset(strap),
      .i_quad_lane_enable(quad), .i_four_wire_command_mode(fw), .i_suspend_cmd(susp),
      .i_resume_cmd(resm), .i_program_busy(pbusy), .i_erase_busy(ebusy),
      .i_row_prog_req(rreq), .i_row_sel(rsel), .i_read_class(rcls), .i_read_load(rload),
      .i_read_step(rstep), .i_read_start(rstart), .o_func(func), .o_read_params_nv(rp_nv),
      .o_read_params(rp), .o_shared_pin_mode(pmode), .o_wp_pin_is_data2(wp2),
      .o_dedicated_reset_enable(dre), .o_protect_at_bottom(pbot), .o_row_prog_allow(rallow),
      .o_dummy_cycles(dcyc), .o_burst_bytes(bbytes), .o_read_addr(raddr));
   ffr_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so));

   // expected dummy count for a read class
   function automatic logic [3:0] f_dummy(ffr_read_class_t c, logic [3:0] f);
      if (f != 4'h0) return f;
      case (c)
         ffr_rc_fast_qpi, ffr_rc_quad_io: return FFR_DUMMY_6;
         ffr_rc_dual_io: return FFR_DUMMY_4;
         default: return FFR_DUMMY_8;
      endcase
   endfunction
   // expected next read address, wrapping inside the aligned window
   function automatic logic [23:0] f_next(logic [23:0] a, logic w, logic [1:0] b);
      logic [23:0] m;
      m = (24'h8 << b) - 24'h1;
      return w ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
   endfunction
   // expected shared pin function
   function automatic ffr_pin_mode_t f_pin(logic q, logic w, logic s, logic dis, logic p7);
      if (q | w) return ffr_pin_data_line_three;
      if ((s & ~dis) | ~p7) return ffr_pin_pause;
      return ffr_pin_restart;
   endfunction
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // counts and verdict
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // wait edges, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   // register write frame with expectation tracking
   task automatic wr(input logic [7:0] op, input logic [7:0] v);
      host.frame(op, v, 16, rd);
      if (op == FFR_OP_SET_RP_NV) exp_nv = v;
      else if (op != FFR_OP_WR_FUNC) exp_rp = v;
      else exp_func = exp_func | (v & 8'hf3);
      tick(2);
   endtask
   // reset with a given package strap, then reset values
   task automatic do_reset(input logic s);
      strap = s;
      rcls = ffr_rc_fast_spi;
      i_reset_n = 1'b0;
      tick(12);
      i_reset_n = 1'b1;
      tick(4);
      exp_func = {7'h00, ~s};
      exp_rp = FFR_RP_RESET;
      exp_nv = FFR_RP_RESET;
      check(func, exp_func);
      check(rp, rp_nv);
      check(rp, exp_rp);
      check(dcyc, FFR_DUMMY_8);
      check(bbytes, FFR_BURST_8);
      check(pmode, ffr_pin_pause);
   endtask
   task automatic pin_scan();
      for (int p = 0; p < 2; p++) begin
         {quad, fw} = 2'h0;
         wr(FFR_OP_SET_RP_V1, {p[0], exp_rp[6:0]});
         for (int m = 0; m < 4; m++) begin
            {fw, quad} = m[1:0];
            tick(3);
            check(pmode, f_pin(quad, fw, strap, exp_func[0], p[0]));
            check(wp2, quad);
            check(dre, strap & ~exp_func[0]);
         end
      end
      {quad, fw} = 2'h0;
   endtask

   // clock
   always #2 i_mclk = ~i_mclk;
   // cycles with the read driver enabled
   always @(posedge i_mclk)
      if (so_oe === 1'b1) oe_cnt++;
   // hang guard
   initial begin
      #350000;
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end
   // main sequence
   initial begin
      i_mclk = 1'b0;
      seed = 32'h263cf22f;
      {susp, resm, pbusy, ebusy, rreq, rload, rstep, quad, fw} = 9'h000;
      rsel = 2'h0;
      rstart = 24'h000000;
      do_reset(1'b1);
      // copy chosen by opcode, refused frames
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         oe_mark = oe_cnt;
         wr(i % 3 == 0 ? FFR_OP_SET_RP_NV : i % 3 == 1 ? FFR_OP_SET_RP_V0 : FFR_OP_SET_RP_V1, d);
         check(oe_cnt, oe_mark);
         check(rp_nv, exp_nv);
         check(rp, exp_rp);
         host.frame(FFR_OP_RD_RP, 8'h00, 16, rd);
         check(rd, exp_rp);
         check(oe_cnt > oe_mark, 1'b1);
         check(so_oe, 1'b0);
      end
      host.frame(FFR_OP_SET_RP_V0, ~exp_rp, 12, rd);
      host.frame(8'h5a, ~exp_rp, 16, rd);
      tick(2);
      check(rp, exp_rp);
      for (int j = 0; j < 16; j++) begin
         wr(FFR_OP_SET_RP_V0, {1'b0, j[3:0], 1'b0, j[1:0]});
         for (int c = 0; c < 6; c++) begin
            rcls = cls_tab[c];
            tick(2);
            check(dcyc, f_dummy(rcls, j[3:0]));
         end
         check(bbytes, FFR_BURST_8 << j[1:0]);
      end
      for (int w = 0; w < 2; w++) begin
         d = $random(seed);
         wr(FFR_OP_SET_RP_V1, {5'h00, w[0], d[1:0]});
         ea = w[0] ? 24'($random(seed)) : 24'hfffff8;
         rstart = ea;
         {rload, rstep} = 2'h3;
         tick(1);
         rload = 1'b0;
         for (int s = 0; s < 70; s++) begin
            check(raddr, ea);
            ea = f_next(ea, w[0], d[1:0]);
            tick(1);
         end
         rstep = 1'b0;
      end
      pin_scan();
      // suspend flags follow the busy operation
      for (int k = 0; k < 3; k++) begin
         {ebusy, pbusy} = 2'h1 << k;
         susp = 1'b1;
         tick(1);
         susp = 1'b0;
         tick(3);
         check(func, exp_func | {4'h0, k == 1, k == 0, 2'h0});
         resm = 1'b1;
         tick(1);
         resm = 1'b0;
         tick(3);
         check(func, exp_func);
      end
      {ebusy, pbusy} = 2'h0;
      // suspend and resume in one cycle: set wins
      {pbusy, susp, resm} = 3'h7;
      tick(1);
      {pbusy, susp, resm} = 3'h0;
      tick(3);
      check(func, exp_func | 8'h04);
      resm = 1'b1;
      tick(1);
      resm = 1'b0;
      tick(3);
      check(func, exp_func);
      for (int i = 0; i < 4; i++) begin
         d = (i == 2) ? 8'h00 : (i == 3) ? 8'hff : 8'($random(seed));
         wr(FFR_OP_WR_FUNC, d);
         check(func, exp_func);
         host.frame(FFR_OP_RD_FUNC, 8'h00, 16, rd);
         check(rd, exp_func);
         check(pbot, exp_func[1]);
         rreq = 1'b1;
         for (int r = 0; r < 4; r++) begin
            rsel = r[1:0];
            tick(1);
            check(rallow, !exp_func[4 + r]);
         end
         rreq = 1'b0;
      end
      pin_scan();
      do_reset(1'b0);
      pin_scan();
      print_verdict();
   end
endmodule
